// File: rtl/motor_timing_map.svh
// register map, reset values and timing figures of the dual motor timing block
`ifndef MOTOR_TIMING_MAP_SVH
`define MOTOR_TIMING_MAP_SVH

`define REG_CTRL 8'h00
`define REG_HALF 8'h04
`define REG_DUTY0 8'h08
`define REG_DUTY1 8'h0c
`define REG_NEXT_SECTOR 8'h10
`define REG_SCHED_RELOAD 8'h14
`define REG_TRIG_EN 8'h18
`define REG_STATUS 8'h1c
`define REG_MASK 8'h20
`define REG_STATE 8'h24
`define REG_TRIG_BASE 8'h40
`define REG_TRIG_LAST 8'h5c

`define CTRL_RUN 0
`define CTRL_MODE0_LSB 1
`define CTRL_MODE0_MSB 2
`define CTRL_MODE1_LSB 3
`define CTRL_MODE1_MSB 4
`define SECT0_LSB 0
`define SECT0_MSB 2
`define SECT1_LSB 4
`define SECT1_MSB 6

`define HALF_RST 16'h0bb8
`define CENTRE 16'h0000
`define DUTY_RST 16'h012c
`define SCHED_RELOAD_RST 13'h0000
`define SCHED_MAX 13'h1770
`define TRIG_MOTOR0 0
`define TRIG_MOTOR1 2
`define TRIG0_RST 13'h0078
`define TRIG2_RST 13'h0c30
`define TRIG_EN_RST 8'h05
`define CMD_OFS_MOTOR0 5'h00
`define CMD_OFS_MOTOR1 5'h03

`define EVT_CURRENT 0
`define EVT_SPEED 1
`define EVT_ADC0 2
`define EVT_ADC1 3
`define EVT_FORCE0 4
`define EVT_FORCE1 5

`define SPEED_LOOP_US 2500
`define PWM_FREQ_HZ 20000

`endif

// File: rtl/motor_timing_pkg.sv
// types shared by the dual motor timing block
package motor_timing_pkg;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_ALIGN = 2'b01,
		MODE_RUN = 2'b11
	} drive_mode_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic start;
		logic [4:0] index;
	} adc_cmd_t;

endpackage

// File: rtl/dual_motor_timing.sv
// dual centre-aligned pwm, trigger scheduler and commutation patterns
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "motor_timing_map.svh"

// Notes on behaviour
// - master counter match on half-period compare gives one reload pulse per period
// - shadow half period and duty move to active copies only on reload
// - centre-aligned count from minus half period up to plus half period
// - half-period compare resets to 3000, counter start to its negative
// - turn-on compare is minus turn-off compare; pulses symmetric about centre
// - master drives a counter sync that restarts the second module counter and the scheduler counter
// - master reload feeds the second module's external sync internally
// - second module reloads at its own mid-period, in the same cycle as the first module's reload
// - all timing logic runs on one motor clock
// - master reload reloads scheduler counter from programmable reload value
// - scheduler starts from its reload value (zero at reset) after reload and counts up to 6000
// - eight trigger events, each fires when counter equals its compare
// - compare 120 starts motor 0 adc sequence at command index zero
// - compare 3120 starts motor 1 adc sequence at command index three
// - alignment: phase a top switched by pwm, phases b and c bottom on
// - speed-loop event every 2.5 ms beside per-period current-loop event
// - run: six sectors, one top and one bottom conduct, third phase off
// - commutation force edge loads preloaded next sector into outputs at once
module dual_motor_timing #(
	parameter int SPEED_DIV = `SPEED_LOOP_US * (`PWM_FREQ_HZ / 1000) / 1000
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire motor_timing_pkg::bus_req_t bus_i,
	output logic [31:0] rdata_o,
	input wire logic [1:0] force_i,
	output logic [11:0] gates_o,
	output logic [7:0] trig_o,
	output motor_timing_pkg::adc_cmd_t adc0_o,
	output motor_timing_pkg::adc_cmd_t adc1_o,
	output logic reload_o,
	output logic sync_o,
	output logic reload1_o,
	output logic speed_o,
	output logic irq_o
);
	import motor_timing_pkg::*;

	generate
		if (SPEED_DIV < 1 || SPEED_DIV > 65535) begin : g_bad_div
			$error("SPEED_DIV out of range");
		end
	endgenerate

	typedef struct packed {
		logic run;
		drive_mode_t mode0;
		drive_mode_t mode1;
		logic [15:0] half_sh;
		logic [15:0] half_act;
		logic [15:0] duty0_sh;
		logic [15:0] duty0_act;
		logic [15:0] duty1_sh;
		logic [15:0] duty1_act;
		logic signed [15:0] cnt0;
		logic signed [15:0] cnt1;
		logic [2:0] next0;
		logic [2:0] next1;
		logic [2:0] sector0;
		logic [2:0] sector1;
		logic [12:0] sched_reload;
		logic [12:0] sched_cnt;
		logic [7:0][12:0] trig_cmp;
		logic [7:0] trig_en;
		logic [7:0] trig;
		logic [1:0] fs1;
		logic [1:0] fs2;
		logic [1:0] fs3;
		logic [1:0] filt;
		logic [5:0] status;
		logic [5:0] mask;
		logic [15:0] speed_cnt;
		logic mreload;
		logic msync;
		logic reload1;
		logic speed_evt;
		adc_cmd_t adc0;
		adc_cmd_t adc1;
		logic irq;
		logic [11:0] gates;
		logic [31:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic drive_mode_t to_mode(input logic [1:0] v);
		case (v)
			2'b01: to_mode = MODE_ALIGN;
			2'b11: to_mode = MODE_RUN;
			default: to_mode = MODE_OFF;
		endcase
	endfunction

	// bit order per motor: {c_bot, c_top, b_bot, b_top, a_bot, a_top}
	function automatic logic [5:0] gate_pattern(input drive_mode_t m, input logic [2:0] s, input logic p);
		logic [5:0] g;
		logic [2:0] top;
		logic [2:0] bot;
		g = 6'h00;
		top = 3'h0;
		bot = 3'h0;
		case (s)
			3'h0: begin
				top = 3'h0;
				bot = 3'h3;
			end
			3'h1: begin
				top = 3'h0;
				bot = 3'h5;
			end
			3'h2: begin
				top = 3'h2;
				bot = 3'h5;
			end
			3'h3: begin
				top = 3'h2;
				bot = 3'h1;
			end
			3'h4: begin
				top = 3'h4;
				bot = 3'h1;
			end
			default: begin
				top = 3'h4;
				bot = 3'h3;
			end
		endcase
		case (m)
			MODE_ALIGN: g = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, p};
			MODE_RUN: begin
				// sectors 6 and 7 are not legal; all switches stay off then
				if (s < 3'h6) begin
					g[top] = p;
					g[bot] = 1'b1;
				end
			end
			default: g = 6'h00;
		endcase
		gate_pattern = g;
	endfunction

	logic match0;
	logic match1;
	logic wrap1;
	logic pwm0_calc;
	logic pwm1_calc;
	logic [1:0] force_edge;
	logic [7:0] trig_hit;
	logic [5:0] events;
	logic rd_status;

	assign match0 = st_r.run && (st_r.cnt0 == $signed(st_r.half_act));
	assign match1 = st_r.run && (st_r.cnt1 == $signed(`CENTRE));
	assign wrap1 = st_r.cnt1 == $signed(st_r.half_act);
	assign pwm0_calc = (st_r.cnt0 >= $signed(16'h0 - st_r.duty0_act)) && (st_r.cnt0 < $signed(st_r.duty0_act));
	assign pwm1_calc = (st_r.cnt1 >= $signed(16'h0 - st_r.duty1_act)) && (st_r.cnt1 < $signed(st_r.duty1_act));
	// only the second and third stages are looked at; the first may be metastable
	assign force_edge = st_r.fs2 & st_r.fs3 & ~st_r.filt;
	assign rd_status = bus_i.re && reg_hit(bus_i.addr, `REG_STATUS);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_trig
			assign trig_hit[gi] = st_r.trig_en[gi] && (st_r.sched_cnt == st_r.trig_cmp[gi]);
		end
	endgenerate

	assign events[`EVT_CURRENT] = match0;
	assign events[`EVT_SPEED] = match0 && (st_r.speed_cnt == 16'(SPEED_DIV - 1));
	assign events[`EVT_ADC0] = trig_hit[`TRIG_MOTOR0];
	assign events[`EVT_ADC1] = trig_hit[`TRIG_MOTOR1];
	assign events[`EVT_FORCE0] = force_edge[0];
	assign events[`EVT_FORCE1] = force_edge[1];

	always_comb begin
		st_nxt = st_r;
		// master counter and double-buffered settings
		if (!st_r.run) begin
			st_nxt.cnt0 = $signed(16'h0 - st_r.half_sh);
			st_nxt.cnt1 = $signed(`CENTRE);
		end else begin
			if (match0) begin
				st_nxt.half_act = st_r.half_sh;
				st_nxt.duty0_act = st_r.duty0_sh;
				st_nxt.cnt0 = $signed(16'h1 - st_r.half_sh);
			end else begin
				st_nxt.cnt0 = st_r.cnt0 + 16'sh1;
			end
			// the second module is restarted half a period shifted by the master sync
			if (match0) begin
				st_nxt.cnt1 = $signed(`CENTRE + 16'h1);
			end else if (wrap1) begin
				st_nxt.cnt1 = $signed(16'h1 - st_r.half_act);
			end else begin
				st_nxt.cnt1 = st_r.cnt1 + 16'sh1;
			end
			if (match1) begin
				st_nxt.duty1_act = st_r.duty1_sh;
			end
		end
		st_nxt.mreload = match0;
		st_nxt.msync = match0;
		st_nxt.reload1 = match1;

		// speed loop divider counts current-loop periods
		if (events[`EVT_SPEED]) begin
			st_nxt.speed_cnt = 16'h0;
		end else if (match0) begin
			st_nxt.speed_cnt = st_r.speed_cnt + 16'h1;
		end
		st_nxt.speed_evt = events[`EVT_SPEED];

		// trigger scheduler
		if (match0) begin
			st_nxt.sched_cnt = st_r.sched_reload;
		end else if (st_r.sched_cnt != `SCHED_MAX) begin
			st_nxt.sched_cnt = st_r.sched_cnt + 13'h1;
		end
		st_nxt.trig = trig_hit;
		st_nxt.adc0.start = trig_hit[`TRIG_MOTOR0];
		st_nxt.adc0.index = `CMD_OFS_MOTOR0;
		st_nxt.adc1.start = trig_hit[`TRIG_MOTOR1];
		st_nxt.adc1.index = `CMD_OFS_MOTOR1;

		// commutation force pins
		st_nxt.fs1 = force_i;
		st_nxt.fs2 = st_r.fs1;
		st_nxt.fs3 = st_r.fs2;
		st_nxt.filt = (st_r.fs2 & st_r.fs3) | (st_r.filt & (st_r.fs2 | st_r.fs3));
		if (force_edge[0]) begin
			st_nxt.sector0 = st_r.next0;
		end
		if (force_edge[1]) begin
			st_nxt.sector1 = st_r.next1;
		end
		st_nxt.gates = {gate_pattern(st_r.mode1, st_nxt.sector1, pwm1_calc),
			gate_pattern(st_r.mode0, st_nxt.sector0, pwm0_calc)};

		// register writes
		if (bus_i.we) begin
			case (bus_i.addr)
				`REG_CTRL: begin
					st_nxt.run = bus_i.wdata[`CTRL_RUN];
					st_nxt.mode0 = to_mode(bus_i.wdata[`CTRL_MODE0_MSB:`CTRL_MODE0_LSB]);
					st_nxt.mode1 = to_mode(bus_i.wdata[`CTRL_MODE1_MSB:`CTRL_MODE1_LSB]);
				end
				`REG_HALF: st_nxt.half_sh = bus_i.wdata[15:0];
				`REG_DUTY0: st_nxt.duty0_sh = bus_i.wdata[15:0];
				`REG_DUTY1: st_nxt.duty1_sh = bus_i.wdata[15:0];
				`REG_NEXT_SECTOR: begin
					st_nxt.next0 = bus_i.wdata[`SECT0_MSB:`SECT0_LSB];
					st_nxt.next1 = bus_i.wdata[`SECT1_MSB:`SECT1_LSB];
				end
				`REG_SCHED_RELOAD: st_nxt.sched_reload = bus_i.wdata[12:0];
				`REG_TRIG_EN: st_nxt.trig_en = bus_i.wdata[7:0];
				`REG_MASK: st_nxt.mask = bus_i.wdata[5:0];
				default: begin
					if (bus_i.addr >= `REG_TRIG_BASE && bus_i.addr <= `REG_TRIG_LAST && bus_i.addr[1:0] == 2'b00) begin
						st_nxt.trig_cmp[bus_i.addr[4:2]] = bus_i.wdata[12:0];
					end
				end
			endcase
		end

		// read clears status, but an event in the same cycle survives
		st_nxt.status = (rd_status ? 6'h00 : st_r.status) | events;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);

		st_nxt.rdata = 32'h0;
		if (bus_i.re) begin
			case (bus_i.addr)
				`REG_CTRL: st_nxt.rdata = {27'h0, st_r.mode1, st_r.mode0, st_r.run};
				`REG_HALF: st_nxt.rdata = {16'h0, st_r.half_sh};
				`REG_DUTY0: st_nxt.rdata = {16'h0, st_r.duty0_sh};
				`REG_DUTY1: st_nxt.rdata = {16'h0, st_r.duty1_sh};
				`REG_NEXT_SECTOR: st_nxt.rdata = {25'h0, st_r.next1, 1'b0, st_r.next0};
				`REG_SCHED_RELOAD: st_nxt.rdata = {19'h0, st_r.sched_reload};
				`REG_TRIG_EN: st_nxt.rdata = {24'h0, st_r.trig_en};
				`REG_STATUS: st_nxt.rdata = {26'h0, st_r.status};
				`REG_MASK: st_nxt.rdata = {26'h0, st_r.mask};
				`REG_STATE: st_nxt.rdata = {9'h0, st_r.sched_cnt, 3'b0, st_r.sector1, 1'b0, st_r.sector0};
				default: begin
					if (bus_i.addr >= `REG_TRIG_BASE && bus_i.addr <= `REG_TRIG_LAST && bus_i.addr[1:0] == 2'b00) begin
						st_nxt.rdata = {19'h0, st_r.trig_cmp[bus_i.addr[4:2]]};
					end
				end
			endcase
		end
	end

	// single clock domain for counters, scheduler and patterns
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= '0;
			st_r.mode0 <= MODE_OFF;
			st_r.mode1 <= MODE_OFF;
			st_r.half_sh <= `HALF_RST;
			st_r.half_act <= `HALF_RST;
			st_r.duty0_sh <= `DUTY_RST;
			st_r.duty0_act <= `DUTY_RST;
			st_r.duty1_sh <= `DUTY_RST;
			st_r.duty1_act <= `DUTY_RST;
			st_r.cnt0 <= $signed(16'h0 - `HALF_RST);
			st_r.sched_reload <= `SCHED_RELOAD_RST;
			st_r.trig_cmp[`TRIG_MOTOR0] <= `TRIG0_RST;
			st_r.trig_cmp[`TRIG_MOTOR1] <= `TRIG2_RST;
			st_r.trig_en <= `TRIG_EN_RST;
			st_r.adc0.index <= `CMD_OFS_MOTOR0;
			st_r.adc1.index <= `CMD_OFS_MOTOR1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;
	assign gates_o = st_r.gates;
	assign trig_o = st_r.trig;
	assign adc0_o = st_r.adc0;
	assign adc1_o = st_r.adc1;
	assign reload_o = st_r.mreload;
	assign sync_o = st_r.msync;
	assign reload1_o = st_r.reload1;
	assign speed_o = st_r.speed_evt;
	assign irq_o = st_r.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_master_match;
		st_r.run && st_r.cnt0 == $signed(st_r.half_act);
	endsequence

	sequence s_restarted;
		reload_o && st_r.cnt1 == 16'sh1 && st_r.sched_cnt == $past(st_r.sched_reload);
	endsequence

	a_reload_on_match: assert property (s_master_match |=> reload_o ##1 !reload_o)
		else $error("reload pulse missing after half-period match");
	a_duty_on_reload: assert property ($changed(st_r.duty0_act) |-> reload_o)
		else $error("duty changed outside reload");
	a_count_start: assert property (reload_o |-> st_r.cnt0 == $signed(16'h1 - st_r.half_act))
		else $error("counter did not restart from minus half period");
	a_reset_values: assert property ($past(srst_i) |-> st_r.half_sh == `HALF_RST && st_r.cnt0 == -16'sd3000)
		else $error("half period reset value wrong");
	a_symmetric_pwm: assert property (st_r.mode0 == MODE_ALIGN ##1 st_r.mode0 == MODE_ALIGN
		|-> gates_o[0] == $past(pwm0_calc))
		else $error("pwm level does not follow symmetric compares");
	a_sync_restart: assert property (s_master_match |=> s_restarted)
		else $error("sync did not restart second module and scheduler");
	a_second_mid: assert property (reload_o && st_r.run |-> reload1_o)
		else $error("second module reload not at its mid period");
	a_sched_limit: assert property (st_r.sched_cnt <= `SCHED_MAX)
		else $error("scheduler counter passed its limit");
	a_motor0_trigger: assert property (st_r.trig_en[`TRIG_MOTOR0] && st_r.sched_cnt == st_r.trig_cmp[`TRIG_MOTOR0]
		|=> adc0_o.start && adc0_o.index == `CMD_OFS_MOTOR0 && trig_o[`TRIG_MOTOR0])
		else $error("motor 0 adc start missing");
	a_motor1_trigger: assert property (adc1_o.start |-> $past(st_r.sched_cnt) == $past(st_r.trig_cmp[`TRIG_MOTOR1])
		&& adc1_o.index == `CMD_OFS_MOTOR1)
		else $error("motor 1 adc start at wrong time");
	a_align_gates: assert property (st_r.mode0 == MODE_ALIGN |=> gates_o[5:1] == 5'b10100)
		else $error("alignment pattern wrong");
	a_speed_period: assert property (speed_o |-> reload_o && st_r.speed_cnt == 16'h0)
		else $error("speed event not on a period boundary");
	a_run_two_switches: assert property (st_r.mode0 == MODE_RUN |=> $countones(gates_o[5:0]) <= 2
		&& !(gates_o[0] && gates_o[1]) && !(gates_o[2] && gates_o[3]) && !(gates_o[4] && gates_o[5]))
		else $error("run pattern drives more than one top and one bottom");
	a_force_load: assert property (force_edge[0] |=> st_r.sector0 == $past(st_r.next0))
		else $error("force edge did not load next sector");

endmodule // dual_motor_timing

// File: tb/inverter_model.sv
// behavioural model of the two inverter power stages
`timescale 1ns/10ps
module inverter_model (
	input wire logic [11:0] gates_i,
	output logic [5:0] hi_o,
	output logic [5:0] lo_o,
	output logic shoot_o
);
	// phase level as the pre-driver would put it on the motor lead
	always_comb begin
		shoot_o = 1'b0;
		for (int p = 0; p < 6; p++) begin
			hi_o[p] = gates_i[2*p] & ~gates_i[2*p+1];
			lo_o[p] = gates_i[2*p+1] & ~gates_i[2*p];
			// both switches of one leg on would short the bus
			shoot_o = shoot_o | (gates_i[2*p] & gates_i[2*p+1]);
		end
	end
endmodule // inverter_model

// File: tb/tb.sv
// self-checking bench of the dual motor timing block
`timescale 1ns/10ps
module tb;
	import motor_timing_pkg::*;
	logic clk_i;
	logic srst_r;
	bus_req_t bus_r;
	logic [1:0] force_r;
	logic [31:0] rdata_o;
	logic [11:0] gates_o;
	logic [7:0] trig_o;
	adc_cmd_t adc0_o;
	adc_cmd_t adc1_o;
	logic reload_o, sync_o, reload1_o, speed_o, irq_o;
	logic [5:0] hi, lo;
	logic shoot;
	logic re_d;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	logic [31:0] m_pop;
	int num_errors = 0;
	int n_tests = 0;
	int d0, d2, s0, s1, s1n;
	logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h48, 8'h18, 8'h1c, 8'h60};
	logic [31:0] rv[9] = '{32'h0, 32'h0bb8, 32'h012c, 32'h012c, 32'h0078, 32'h0c30, 32'h05, 32'h0, 32'h0};

	dual_motor_timing #(.SPEED_DIV(2)) dual_motor_timing_inst (
		.clk_i(clk_i), .srst_i(srst_r), .bus_i(bus_r), .rdata_o(rdata_o), .force_i(force_r),
		.gates_o(gates_o), .trig_o(trig_o), .adc0_o(adc0_o), .adc1_o(adc1_o), .reload_o(reload_o),
		.sync_o(sync_o), .reload1_o(reload1_o), .speed_o(speed_o), .irq_o(irq_o)
	);
	inverter_model inverter_model_inst (.gates_i(gates_o), .hi_o(hi), .lo_o(lo), .shoot_o(shoot));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task results;
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk_i) begin
		// mask popped first; argument order of a call is not fixed
		if (re_d === 1'b1) begin
			m_pop = mq.pop_front();
			chk("rdata", eq.pop_front() & m_pop, rdata_o & m_pop);
		end
		re_d <= bus_r.re & ~srst_r;
	end

	// tasks hold the strobe until the next call or idle, so no signal is set twice per step
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus_r <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus_r <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
		eq.push_back(e);
		mq.push_back(m);
		@(posedge clk_i);
	endtask

	task idle;
		bus_r <= '0;
		@(posedge clk_i);
	endtask

	task wait_reload;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (reload_o !== 1'b1 && n < 7000);
		if (reload_o !== 1'b1) begin
			num_errors++;
			$display("BAD reload_wait exp 1 got 0");
			results();
		end
	endtask

	// one pwm period sampled edge by edge; o = edges already spent since the reload
	// spe = speed events due in this period; with SPEED_DIV 2 only every other reload has one
	task chk_period(input int o, input int dw, input int spe);
		int rl, t0, t1, w, sp, b0, b1;
		rl = 0; t0 = 0; t1 = 0; w = 0; sp = 0; b0 = 0; b1 = 0;
		for (int i = 1; i <= 6000 - o; i++) begin
			@(posedge clk_i);
			if (reload_o === 1'b1 && sync_o === 1'b1 && reload1_o === 1'b1) rl = i;
			if (trig_o[0] === 1'b1 && adc0_o.start === 1'b1) t0 = i;
			if (trig_o[2] === 1'b1 && adc1_o.start === 1'b1) t1 = i;
			if (gates_o[0] === 1'b1) w++;
			if (speed_o === 1'b1) sp++;
			if (lo[2:0] !== 3'b110 || hi[2:1] !== 2'b00) b0++;
			if (shoot !== 1'b0 || $countones(lo[5:3]) != 1 || $countones(hi[5:3]) > 1) b1++;
		end
		chk("reload", 6000 - o, rl);
		chk("trig0", 121 - o, t0);
		chk("trig2", 3121 - o, t1);
		chk("pwm_width", 2 * dw, w);
		chk("speed", spe, sp);
		chk("align", 0, b0);
		chk("sector", 0, b1);
	endtask

	initial begin
		void'($urandom(56));
		bus_r = '0;
		force_r = 2'b00;
		srst_r = 1'b1;
		repeat (10) @(posedge clk_i);
		srst_r <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i], 32'hffffffff);
		chk("adc0_index", 32'h0, adc0_o.index);
		chk("adc1_index", 32'h3, adc1_o.index);
		d0 = 100 + $urandom_range(1900);
		d2 = 100 + $urandom_range(1900);
		s0 = $urandom_range(5);
		s1 = $urandom_range(5);
		wr(8'h20, 32'h3f);
		wr(8'h08, d0);
		wr(8'h10, (s1 << 4) | s0);
		// run, motor 0 aligning, motor 1 running
		wr(8'h00, 32'h1b);
		idle();
		wait_reload();
		// new duty must wait for the next reload
		wr(8'h08, d2);
		idle();
		chk_period(2, d0, 1);
		chk_period(0, d2, 0);
		chk("irq_set", 1, irq_o);
		rd(8'h1c, 32'h0f, 32'hff);
		rd(8'h1c, 32'h00, 32'hff);
		idle();
		chk("irq_clear", 0, irq_o);
		s1n = (s1 + 1 + $urandom_range(4)) % 6;
		wr(8'h10, (s1n << 4) | s0);
		idle();
		force_r <= 2'b10;
		repeat (6) @(posedge clk_i);
		force_r <= 2'b00;
		rd(8'h24, s1n << 4, 32'h70);
		rd(8'h1c, 32'h20, 32'h20);
		idle();
		wait_reload();
		chk_period(0, d2, 0);
		// second reset in mid-run
		srst_r <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_r <= 1'b0;
		chk("gates_reset", 0, gates_o);
		rd(8'h08, 32'h012c, 32'hffffffff);
		idle();
		idle();
		results();
	end
endmodule // tb
